/* File: hdl/uart_irq_pkg.sv */
// constants, codes and state layout for the interrupt id / enhanced ctrl
// block; assumes a byte-wide register port with 4-bit register indices
package uart_irq_pkg;

  // register indices (fifo_control is written where the id is read)
  localparam logic [3:0] IDX_INT_ENABLE   = 4'h1;
  localparam logic [3:0] IDX_SOURCE_FIFO  = 4'h2;
  localparam logic [3:0] IDX_MODEM_CTRL   = 4'h4;
  localparam logic [3:0] IDX_FLOW_THRESH  = 4'h6;
  localparam logic [3:0] IDX_ENHANCED     = 4'h8;

  // enhanced_feature_ctrl fields
  localparam int EFR_CTS_EN   = 7;
  localparam int EFR_RTS_EN   = 6;
  localparam int EFR_SPEC_EN  = 5;
  localparam int EFR_WR_GATE  = 4;

  // interrupt_enable fields
  localparam int IER_RHR   = 0;
  localparam int IER_THR   = 1;
  localparam int IER_LSR   = 2;
  localparam int IER_MODEM = 3;
  localparam int IER_XOFF  = 5;
  localparam int IER_RTS   = 6;
  localparam int IER_CTS   = 7;

  // gated write masks: high bits need the write gate
  localparam logic [7:0] IER_GATED_MASK = 8'hF0;
  localparam logic [7:0] FCR_GATED_MASK = 8'h30;
  localparam logic [7:0] MCR_GATED_MASK = 8'hE0;
  localparam int         MCR_RTS_BIT    = 1;
  localparam int         FCR_FIFO_EN    = 0;

  // flow thresholds count in steps of four characters
  localparam int THRESH_SHIFT = 2;

  // source slots, index 0 is the highest priority
  localparam int NUM_SRC  = 8;
  localparam int SRC_LSR  = 0;
  localparam int SRC_RTO  = 1;
  localparam int SRC_RHR  = 2;
  localparam int SRC_THR  = 3;
  localparam int SRC_MDM  = 4;
  localparam int SRC_PIN  = 5;
  localparam int SRC_XOFF = 6;
  localparam int SRC_CTSR = 7;

  localparam logic [5:0] SRC_CODE [NUM_SRC] = '{
    6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h30, 6'h10, 6'h20};

  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic [7:0] fifo_control;
    logic [7:0] modem_control;
    logic [7:0] flow_threshold;
    logic [7:0] enhanced_feature_ctrl;
    logic       cts_s1;
    logic       cts_s2;
    logic       cts_s3;
    logic       cts_lvl;
    logic       tx_space_d;
    logic       thr_pend;
    logic       spec_pend;
    logic       xoff_pend;
    logic       cts_pend;
    logic       rts_pend;
    logic       rts_n;
    logic       irq_n;
    logic       tx_halt;
    logic [3:0] sw_flow;
    logic [7:0] rdata;
  } state_s;

  // tx space memory starts high: a fifo with room at reset is no edge
  localparam state_s STATE_RESET = '{
    interrupt_enable: 8'h00, fifo_control: 8'h00, modem_control: 8'h00, flow_threshold: 8'h00,
    enhanced_feature_ctrl: 8'h00, cts_s1: 1'b1, cts_s2: 1'b1, cts_s3: 1'b1,
    cts_lvl: 1'b1, tx_space_d: 1'b1, thr_pend: 1'b0, spec_pend: 1'b0,
    xoff_pend: 1'b0, cts_pend: 1'b0, rts_pend: 1'b0, rts_n: 1'b1,
    irq_n: 1'b1, tx_halt: 1'b0, sw_flow: 4'h0, rdata: 8'h00};

endpackage

/* File: hdl/irq_prio_if.sv */
// carrier between the control block and its priority encoder
// assumes the encoder is purely combinational
`timescale 1ns/1ps
interface irq_prio_if;
  logic [7:0] pend;
  logic [5:0] code;
  logic       any;
  modport src (output pend, input code, input any);
  modport enc (input pend, output code, output any);
endinterface

/* File: hdl/irq_prio_encoder.sv */
// picks the highest-priority enabled pending source and its id code
// assumes pend already carries the enable gating
`timescale 1ns/1ps
module irq_prio_encoder
  import uart_irq_pkg::*;
(
  irq_prio_if.enc pr
);
  // walk from lowest to highest so the highest priority wins
  always_comb begin
    pr.code = 6'h01;
    pr.any  = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pr.pend[i]) begin
        pr.code = SRC_CODE[i];
        pr.any  = 1'b1;
      end
    end
  end
endmodule

/* File: hdl/uart_irq_id_enhanced_ctrl.sv */
// interrupt source identification and enhanced feature control
// assumes a byte register port, pending flags and fifo level from datapath
//
// Functional notes
// - id register is 8-bit, read-only
// - id bits 7:6 mirror fifo enable
// - id bit 0 low when interrupt pending
// - report highest source; codes for priorities 1-3
// - codes for priorities 4 to 7
// - cts/rts source only on low-to-high transition
// - cts flow enable halts tx on cts high
// - rts flow by halt and resume thresholds
// - special char matched, stored, flagged in id
// - write gate for extended enable/control fields
// - bits 3:0 select software flow mode
// - flow and detect enables clear at reset
// - sources count only when enabled, except io pin change
// - re-enabling tx interrupt raises nothing new
`timescale 1ns/1ps
module uart_irq_id_enhanced_ctrl
  import uart_irq_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // pending sources from the datapath
  input  wire logic       line_status_err,
  input  wire logic       rx_timeout,
  input  wire logic       rx_data_ready,
  input  wire logic       tx_space_ok,
  input  wire logic       tx_holding_write,
  input  wire logic       modem_change,
  input  wire logic       io_pin_change,
  input  wire logic       xoff_received,
  // received characters and fifo level
  input  wire logic       rx_char_valid,
  input  wire logic [7:0] rx_char,
  input  wire logic [7:0] second_stop_char,
  input  wire logic [6:0] rx_level,
  // pins and controls
  input  wire logic       cts_n,
  output logic            rts_n,
  output logic            irq_n,
  output logic            tx_halt,
  output logic      [3:0] sw_flow_mode,
  output logic            fifo_enable
);
  import uart_irq_pkg::*;

  state_s     r_reg;
  state_s     r_next;
  irq_prio_if pr ();

  logic       id_read;
  logic       rts_rise;
  logic       cts_rise;
  logic       spec_hit;
  logic [6:0] halt_lvl;
  logic [6:0] resume_lvl;

  irq_prio_encoder u_enc (
    .pr (pr)
  );

  assign id_read  = reg_rd && (reg_addr == IDX_SOURCE_FIFO);
  assign halt_lvl   = {1'b0, r_reg.flow_threshold[3:0], 2'b00};
  assign resume_lvl = {1'b0, r_reg.flow_threshold[7:4], 2'b00};
  assign spec_hit = rx_char_valid && r_reg.enhanced_feature_ctrl[EFR_SPEC_EN]
                    && (rx_char == second_stop_char);

  // enable gating of every source except io_pin_change
  always_comb begin
    pr.pend           = '0;
    pr.pend[SRC_LSR]  = line_status_err && r_reg.interrupt_enable[IER_LSR];
    pr.pend[SRC_RTO]  = rx_timeout && r_reg.interrupt_enable[IER_RHR];
    pr.pend[SRC_RHR]  = rx_data_ready && r_reg.interrupt_enable[IER_RHR];
    pr.pend[SRC_THR]  = r_reg.thr_pend && r_reg.interrupt_enable[IER_THR];
    pr.pend[SRC_MDM]  = modem_change && r_reg.interrupt_enable[IER_MODEM];
    pr.pend[SRC_PIN]  = io_pin_change;
    pr.pend[SRC_XOFF] = (r_reg.xoff_pend || r_reg.spec_pend)
                        && r_reg.interrupt_enable[IER_XOFF];
    pr.pend[SRC_CTSR] = (r_reg.cts_pend && r_reg.interrupt_enable[IER_CTS])
                        || (r_reg.rts_pend && r_reg.interrupt_enable[IER_RTS]);
  end

  always_comb begin
    r_next   = r_reg;
    rts_rise = 1'b0;
    cts_rise = 1'b0;

    // pin synchroniser: a change counts once stages two and three agree
    r_next.cts_s1 = cts_n;
    r_next.cts_s2 = r_reg.cts_s1;
    r_next.cts_s3 = r_reg.cts_s2;
    if (r_reg.cts_s2 == r_reg.cts_s3) begin
      r_next.cts_lvl = r_reg.cts_s3;
      cts_rise = r_reg.cts_s3 && !r_reg.cts_lvl;
    end

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        IDX_INT_ENABLE: begin
          r_next.interrupt_enable = r_reg.enhanced_feature_ctrl[EFR_WR_GATE] ? reg_wdata
            : (r_reg.interrupt_enable & IER_GATED_MASK) | (reg_wdata & ~IER_GATED_MASK);
        end
        IDX_SOURCE_FIFO: begin
          r_next.fifo_control = r_reg.enhanced_feature_ctrl[EFR_WR_GATE] ? reg_wdata
            : (r_reg.fifo_control & FCR_GATED_MASK) | (reg_wdata & ~FCR_GATED_MASK);
        end
        IDX_MODEM_CTRL: begin
          r_next.modem_control = r_reg.enhanced_feature_ctrl[EFR_WR_GATE] ? reg_wdata
            : (r_reg.modem_control & MCR_GATED_MASK) | (reg_wdata & ~MCR_GATED_MASK);
        end
        IDX_FLOW_THRESH: r_next.flow_threshold = reg_wdata;
        IDX_ENHANCED:    r_next.enhanced_feature_ctrl = reg_wdata;
        default: ;
      endcase
    end

    // register reads; the id register has no write path at all
    if (reg_rd) begin
      unique case (reg_addr)
        IDX_INT_ENABLE:  r_next.rdata = r_reg.interrupt_enable;
        IDX_SOURCE_FIFO: r_next.rdata = {{2{r_reg.fifo_control[FCR_FIFO_EN]}},
                                         pr.code[5:1], !pr.any};
        IDX_MODEM_CTRL:  r_next.rdata = r_reg.modem_control;
        IDX_FLOW_THRESH: r_next.rdata = r_reg.flow_threshold;
        IDX_ENHANCED:    r_next.rdata = r_reg.enhanced_feature_ctrl;
        default:         r_next.rdata = 8'h00_00;
      endcase
    end

    // reading the id acknowledges the event source it reports, so the
    // next read shows the next one down
    if (id_read && pr.any) begin
      if (pr.code == SRC_CODE[SRC_THR]) begin
        r_next.thr_pend = 1'b0;
      end
      if (pr.code == SRC_CODE[SRC_XOFF]) begin
        r_next.xoff_pend = 1'b0;
        r_next.spec_pend = 1'b0;
      end
      if (pr.code == SRC_CODE[SRC_CTSR]) begin
        r_next.cts_pend = 1'b0;
        r_next.rts_pend = 1'b0;
      end
    end
    if (tx_holding_write) begin
      r_next.thr_pend = 1'b0;
    end

    // rts flow: hysteresis between halt and resume levels
    if (r_reg.enhanced_feature_ctrl[EFR_RTS_EN]) begin
      if (rx_level >= halt_lvl) begin
        r_next.rts_n = 1'b1;
      end else if (rx_level <= resume_lvl) begin
        r_next.rts_n = 1'b0;
      end
    end else begin
      r_next.rts_n = !r_reg.modem_control[MCR_RTS_BIT];
    end
    rts_rise = r_next.rts_n && !r_reg.rts_n;

    // sets come last so an event in a clearing cycle survives;
    // only an edge of tx space sets the flag, never an enable write
    r_next.tx_space_d = tx_space_ok;
    if (tx_space_ok && !r_reg.tx_space_d) begin
      r_next.thr_pend = 1'b1;
    end
    if (spec_hit) begin
      r_next.spec_pend = 1'b1;
    end
    if (xoff_received) begin
      r_next.xoff_pend = 1'b1;
    end
    if (cts_rise) begin
      r_next.cts_pend = 1'b1;
    end
    if (rts_rise) begin
      r_next.rts_pend = 1'b1;
    end

    r_next.irq_n   = !pr.any;
    r_next.tx_halt = r_reg.enhanced_feature_ctrl[EFR_CTS_EN] && r_reg.cts_lvl;
    r_next.sw_flow = r_reg.enhanced_feature_ctrl[3:0];
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      r_reg <= STATE_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata    = r_reg.rdata;
  assign rts_n        = r_reg.rts_n;
  assign irq_n        = r_reg.irq_n;
  assign tx_halt      = r_reg.tx_halt;
  assign sw_flow_mode = r_reg.sw_flow;
  assign fifo_enable  = r_reg.fifo_control[FCR_FIFO_EN];

endmodule

/* File: tb/uart_irq_monitor.sv */
// port checker for the id / enhanced ctrl block
// assumes it is bound onto the top module
`timescale 1ns/1ps
module uart_irq_monitor
  import uart_irq_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // pins and controls
  input wire logic       cts_n,
  input wire logic       rts_n,
  input wire logic       irq_n,
  input wire logic       tx_halt,
  input wire logic [3:0] sw_flow_mode,
  input wire logic       fifo_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire id_rd = reg_rd && reg_addr == IDX_SOURCE_FIFO;

  mirror_bits_a: assert property (id_rd |=>
    reg_rdata[7:6] == {2{$past(fifo_enable)}}) else $error("top bits");
  idle_code_a: assert property (id_rd |=>
    !reg_rdata[0] || reg_rdata[5:1] == 5'h00) else $error("idle code");
  code_set_a: assert property (id_rd |=> reg_rdata[0] ||
    reg_rdata[5:0] inside {6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h30,
    6'h10, 6'h20}) else $error("bad code");
  irq_match_a: assert property (id_rd |=>
    reg_rdata[0] == irq_n) else $error("irq and id differ");
  reset_vals_a: assert property (disable iff (1'b0) !reset_n |=>
    rts_n && irq_n && !tx_halt && !fifo_enable && sw_flow_mode == 4'h0)
    else $error("reset values");
  flow_copy_a: assert property (reg_wr && reg_addr == IDX_ENHANCED |=>
    ##1 sw_flow_mode == $past(reg_wdata[3:0], 2)) else $error("flow mode");
  fifo_bit_a: assert property (reg_wr && reg_addr == IDX_SOURCE_FIFO
    |=> fifo_enable == $past(reg_wdata[0])) else $error("fifo enable");
  cts_low_a: assert property (!cts_n [*7] |=> !tx_halt)
    else $error("halt while cts low");
  cover property (id_rd ##1 !reg_rdata[0]);
  cover property (tx_halt);
  cover property ($rose(rts_n));
endmodule

bind uart_irq_id_enhanced_ctrl uart_irq_monitor mon (.sys_clk(sys_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .cts_n(cts_n), .rts_n(rts_n), .irq_n(irq_n), .tx_halt(tx_halt),
  .sw_flow_mode(sw_flow_mode), .fifo_enable(fifo_enable));

/* File: tb/host_model.sv */
// host side of the register port: write and read cycles
// assumes one call at a time, started at a clock edge
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       sys_clk,
  // register port
  output logic      [3:0] reg_addr = 4'h0,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  output logic      [7:0] reg_wdata = 8'h00,
  input  wire logic [7:0] reg_rdata
);
  // modem and pin causes are read elsewhere, not here
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  // data is steady a cycle after the taking edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

/* File: tb/test_uart_irq_id_enhanced_ctrl.sv */
// self-checking bench for the id / enhanced ctrl block
// assumes host_model and the bound monitor are compiled first
`timescale 1ns/1ps
module test_uart_irq_id_enhanced_ctrl;
  import uart_irq_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  src = 8'h00;
  logic        rx_char_valid = 1'b0;
  logic        hold_wr = 1'b0;
  logic [7:0]  rx_char = 8'h00;
  logic [7:0]  stop_char = 8'h00;
  logic [6:0]  rx_level = 7'h00;
  logic        rts_n;
  logic        irq_n;
  logic        tx_halt;
  logic        fifo_enable;
  logic [3:0]  sw_flow_mode;
  logic [31:0] seed = 32'h2f25_2ff5;
  logic [7:0]  v;
  logic        en;
  int          i;
  int          n_fail = 0;
  int          n_tests = 0;

  always #25 sys_clk = ~sys_clk;

  host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // src bit 7 drives the cts pin, so an idle bench keeps cts active
  uart_irq_id_enhanced_ctrl DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .line_status_err(src[0]), .rx_timeout(src[1]), .rx_data_ready(src[2]),
    .tx_space_ok(src[3]), .tx_holding_write(hold_wr), .modem_change(src[4]),
    .io_pin_change(src[5]), .xoff_received(src[6]),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .second_stop_char(stop_char), .rx_level(rx_level), .cts_n(src[7]),
    .rts_n(rts_n), .irq_n(irq_n), .tx_halt(tx_halt),
    .sw_flow_mode(sw_flow_mode), .fifo_enable(fifo_enable));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // id byte with fifo enabled, source i pending
  function automatic logic [7:0] exp_id(input int k);
    logic [5:0] c [8] = '{6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h30,
                          6'h10, 6'h20};
    return {2'b11, c[k]};
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    host.rd(IDX_ENHANCED, v);
    chk(v, 8'h00);
    chk({rts_n, irq_n, tx_halt, fifo_enable, sw_flow_mode}, 8'hC0);
    host.wr(IDX_INT_ENABLE, 8'hFF);
    host.rd(IDX_INT_ENABLE, v);
    chk(v, 8'h0F);
    host.wr(IDX_ENHANCED, 8'h10);
    host.wr(IDX_INT_ENABLE, 8'hFF);
    host.rd(IDX_INT_ENABLE, v);
    chk(v, 8'hFF);
    host.wr(IDX_SOURCE_FIFO, 8'hFE);
    host.rd(IDX_SOURCE_FIFO, v);
    chk(v, 8'h01);
    host.wr(IDX_SOURCE_FIFO, 8'h01);
    $display("register test done");
    for (int k = 0; k < 16; k++) begin
      seed = xs(seed);
      i = int'(seed[2:0]);
      // edge-set flags stay enabled so a hidden flag cannot linger
      en = seed[8] || i inside {3, 5, 6, 7};
      host.wr(IDX_INT_ENABLE, en ? 8'hFF : 8'hF0);
      src <= 8'h01 << i;
      repeat (6) @(posedge sys_clk);
      chk({7'h00, irq_n}, {7'h00, !en});
      host.rd(IDX_SOURCE_FIFO, v);
      chk(v, en ? exp_id(i) : 8'hC1);
      src <= 8'h00;
      repeat (6) @(posedge sys_clk);
      host.rd(IDX_SOURCE_FIFO, v);
      chk(v, i == 6 ? exp_id(6) : 8'hC1);
      host.rd(IDX_SOURCE_FIFO, v);
      chk(v, 8'hC1);
    end
    $display("source test done");
    host.wr(IDX_INT_ENABLE, 8'hFF);
    src <= 8'h05;
    host.rd(IDX_SOURCE_FIFO, v);
    chk(v, exp_id(0));
    src <= 8'h0C;
    host.rd(IDX_SOURCE_FIFO, v);
    chk(v, exp_id(2));
    src <= 8'h08;
    host.rd(IDX_SOURCE_FIFO, v);
    chk(v, exp_id(3));
    host.wr(IDX_INT_ENABLE, 8'hFD);
    host.wr(IDX_INT_ENABLE, 8'hFF);
    host.rd(IDX_SOURCE_FIFO, v);
    chk(v, 8'hC1);
    // tx space edge and holding write in one cycle: the set wins
    src <= 8'h00;
    @(posedge sys_clk);
    src <= 8'h08;
    hold_wr <= 1'b1;
    @(posedge sys_clk);
    hold_wr <= 1'b0;
    host.rd(IDX_SOURCE_FIFO, v);
    chk(v, exp_id(3));
    // a holding write alone clears the tx space source
    src <= 8'h00;
    @(posedge sys_clk);
    src <= 8'h08;
    @(posedge sys_clk);
    hold_wr <= 1'b1;
    @(posedge sys_clk);
    hold_wr <= 1'b0;
    host.rd(IDX_SOURCE_FIFO, v);
    chk(v, 8'hC1);
    $display("priority test done");
    host.wr(IDX_ENHANCED, 8'h90);
    src <= 8'h80;
    repeat (7) @(posedge sys_clk);
    chk({7'h00, tx_halt}, 8'h01);
    host.wr(IDX_ENHANCED, 8'h10);
    repeat (7) @(posedge sys_clk);
    chk({7'h00, tx_halt}, 8'h00);
    src <= 8'h00;
    host.wr(IDX_FLOW_THRESH, 8'h14);
    host.wr(IDX_ENHANCED, 8'h50);
    for (int k = 0; k < 4; k++) begin
      // resume level, hold low, halt level, hold high
      rx_level <= k == 0 ? 7'h04 : k == 1 ? 7'h0F : k == 2 ? 7'h10 : 7'h05;
      repeat (3) @(posedge sys_clk);
      chk({7'h00, rts_n}, {7'h00, k >= 2});
    end
    $display("flow test done");
    seed = xs(seed);
    stop_char <= seed[7:0];
    rx_char <= seed[7:0] ^ 8'h01;
    for (int k = 0; k < 2; k++) begin
      host.wr(IDX_ENHANCED, 8'h30);
      rx_char_valid <= 1'b1;
      @(posedge sys_clk);
      rx_char_valid <= 1'b0;
      rx_char <= seed[7:0];
      host.rd(IDX_SOURCE_FIFO, v);
      chk(v, exp_id(k == 0 ? 7 : 6));
    end
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      host.wr(IDX_ENHANCED, seed[7:0]);
      host.rd(IDX_ENHANCED, v);
      chk(v, seed[7:0]);
      chk({4'h0, sw_flow_mode}, {4'h0, seed[3:0]});
    end
    $display("enhanced test done");
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    host.rd(IDX_ENHANCED, v);
    chk(v, 8'h00);
    chk({rts_n, irq_n, tx_halt, fifo_enable, sw_flow_mode}, 8'hC0);
    $display("reset test done");
    report_and_stop();
  end
endmodule
